// ### src/port_shaper_params.svh
`ifndef PORT_SHAPER_PARAMS_SVH
`define PORT_SHAPER_PARAMS_SVH

// Register indices; byte address is four times the index
`define IDX_EGRESS_LIMITS   16'h050a
`define IDX_PHY_DIAG        16'h0510
`define IDX_PORT_CONFIG     16'h0520
`define IDX_IRQ_STATUS      16'h0522
`define IDX_IRQ_MASK        16'h0524
`define IDX_SHAPER_STATUS   16'h0526
`define ADDR_EGRESS_LIMITS  16'h1428
`define ADDR_PHY_DIAG       16'h1440
`define ADDR_PORT_CONFIG    16'h1480
`define ADDR_IRQ_STATUS     16'h1488
`define ADDR_IRQ_MASK       16'h1490
`define ADDR_SHAPER_STATUS  16'h1498

// Egress limits fields
`define EGR_PRI0_LSB        0
`define EGR_FIELD_W         4
`define EGR_RESET           16'h0000

// Diagnostic register fields
`define DIAG_NEAR_SHORT_BIT 15
`define DIAG_RESULT_MSB     14
`define DIAG_RESULT_LSB     13
`define DIAG_RUNNING_BIT    12
`define DIAG_FORCE_LINK_BIT 11
`define DIAG_PWR_SAVE_BIT   10
`define DIAG_LOOPBACK_BIT   9
`define DIAG_COUNT_MSB      8
`define DIAG_PWR_SAVE_RESET 1'b1

// Port configuration fields
`define CFG_MULTI_QUEUE_BIT 0
`define CFG_TEST_START_BIT  1
`define CFG_MULTI_QUEUE_RST 1'b1

// Interrupt status fields
`define IRQ_TEST_DONE_BIT   0
`define IRQ_TEST_FAULT_BIT  1
`define IRQ_W               2

// Rate codes
`define RATE_UNLIMITED      4'h0
`define RATE_FIRST_ABOVE_10M 4'h9

// Shaper timing: credit refilled once per millisecond
`define CLK_FREQ_HZ         40000000
`define SHAPER_TICK_MS      1
`define SHAPER_TICK_CYCLES  (`CLK_FREQ_HZ / 1000 * `SHAPER_TICK_MS)
`define SHAPER_CREDIT_CAP   18'h2_0000
`define SHAPER_BYTE_BITS    18'h0_0008

`endif

// ### src/port_shaper_pkg.sv
package port_shaper_pkg;
  typedef logic [3:0]  rate_code_t;
  typedef logic [17:0] credit_t;
  typedef logic [1:0]  diag_result_t;
  typedef enum logic {DIAG_IDLE, DIAG_RUN} diag_state_t;
endpackage

// ### src/shaper_if.sv
`timescale 1ns/1ps
interface shaper_if #(parameter int NQ = 4);
  import port_shaper_pkg::*;
  rate_code_t       eff_code [NQ];
  logic             tick;
  logic [NQ-1:0]    tx_req;
  logic [NQ-1:0]    tx_grant;
  logic [NQ-1:0]    throttled;
  modport ctrl  (output eff_code, output tick, output tx_req, input tx_grant, input throttled);
  modport shape (input eff_code, input tick, input tx_req, output tx_grant, output throttled);
endinterface

// ### src/egress_shaper.sv
`timescale 1ns/1ps
`include "port_shaper_params.svh"
module egress_shaper #(
  parameter int NQ = 4
) (
  input  wire logic    sys_clk_i,
  input  wire logic    sys_rst_i,
  shaper_if.shape      sh
);
  import port_shaper_pkg::*;

  // Refill per tick in bits, equal to the rate in Kbps for a 1 ms tick
  function automatic credit_t refill_bits(input rate_code_t code);
    case (code)
      4'h1:    refill_bits = 18'h0_0040;
      4'h2:    refill_bits = 18'h0_0080;
      4'h3:    refill_bits = 18'h0_0100;
      4'h4:    refill_bits = 18'h0_0200;
      4'h5:    refill_bits = 18'h0_03e8;
      4'h6:    refill_bits = 18'h0_07d0;
      4'h7:    refill_bits = 18'h0_0fa0;
      4'h8:    refill_bits = 18'h0_1f40;
      4'h9:    refill_bits = 18'h0_3e80;
      4'ha:    refill_bits = 18'h0_7d00;
      4'hb:    refill_bits = 18'h0_bb80;
      4'hc:    refill_bits = 18'h0_fa00;
      4'hd:    refill_bits = 18'h1_1940;
      4'he:    refill_bits = 18'h1_3880;
      4'hf:    refill_bits = 18'h1_57c0;
      default: refill_bits = 18'h0_0000;
    endcase
  endfunction

  for (genvar q = 0; q < NQ; q++) begin : g_queue
    credit_t credit_r;
    logic    unlimited;
    logic    can_send;
    logic [18:0] sum;
    assign unlimited = (sh.eff_code[q] == `RATE_UNLIMITED);
    assign can_send  = unlimited || (credit_r >= `SHAPER_BYTE_BITS);
    assign sum       = {1'b0, credit_r} + (sh.tick ? {1'b0, refill_bits(sh.eff_code[q])} : 19'h0_0000)
                       - ((sh.tx_req[q] && can_send && !unlimited) ? {1'b0, `SHAPER_BYTE_BITS} : 19'h0_0000);

    // Bytes are held back, never dropped, until credit returns
    always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
        credit_r       <= 18'h0_0000;
        sh.tx_grant[q] <= 1'b0;
        sh.throttled[q] <= 1'b0;
      end else begin
        sh.tx_grant[q]  <= sh.tx_req[q] && can_send;
        sh.throttled[q] <= sh.tx_req[q] && !can_send;
        if (unlimited)
          credit_r <= 18'h0_0000;
        else if (sum > {1'b0, `SHAPER_CREDIT_CAP})
          credit_r <= `SHAPER_CREDIT_CAP;
        else
          credit_r <= sum[17:0];
      end
    end
  end
endmodule

// ### src/port_rate_shaper_cable_diag.sv
`timescale 1ns/1ps
`include "port_shaper_params.svh"
module port_rate_shaper_cable_diag #(
  parameter int NQ          = 4,
  parameter int TICK_CYCLES = `SHAPER_TICK_CYCLES
) (
  input  wire logic                           sys_clk_i,
  input  wire logic                           sys_rst_i,
  input  wire logic                           psel_i,
  input  wire logic                           penable_i,
  input  wire logic                           pwrite_i,
  input  wire logic [15:0]                    paddr_i,
  input  wire logic [31:0]                    pwdata_i,
  input  wire logic [3:0]                     pstrb_i,
  output logic      [31:0]                    prdata_o,
  output logic                                pready_o,
  output logic                                pslverr_o,
  input  wire logic [NQ-1:0]                  tx_req_i,
  output logic      [NQ-1:0]                  tx_grant_o,
  input  wire logic                           link_speed_10_i,
  input  wire logic                           link_good_i,
  input  wire logic                           diag_done_i,
  input  wire port_shaper_pkg::diag_result_t  diag_result_i,
  input  wire logic                           diag_near_short_i,
  input  wire logic [8:0]                     diag_fault_count_i,
  output logic                                diag_start_o,
  output logic                                force_link_o,
  output logic                                power_save_en_o,
  output logic                                remote_loopback_o,
  output logic                                irq_o
);
  import port_shaper_pkg::*;

  if (NQ != 4) begin : g_bad_nq
    $error("Egress limits register holds exactly four queues");
  end
  if (TICK_CYCLES < 1 || TICK_CYCLES > 65535) begin : g_bad_tick
    $error("Tick count must fit the 16-bit divider");
  end

  shaper_if #(.NQ(NQ)) sh ();

  // Pin inputs: two flops before use
  localparam int SW = 15;
  logic [SW-1:0] pin_meta_r;
  logic [SW-1:0] pin_sync_r;
  logic          done_seen_r;
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      pin_meta_r  <= 15'h0000;
      pin_sync_r  <= 15'h0000;
      done_seen_r <= 1'b0;
    end else begin
      pin_meta_r  <= {link_speed_10_i, link_good_i, diag_done_i, diag_result_i,
                      diag_near_short_i, diag_fault_count_i};
      pin_sync_r  <= pin_meta_r;
      done_seen_r <= pin_sync_r[12];
    end
  end

  logic         speed_10m;
  logic         link_good;
  logic         done_rise;
  diag_result_t res_sync;
  logic         short_sync;
  logic [8:0]   count_sync;
  assign speed_10m  = pin_sync_r[14];
  assign link_good  = pin_sync_r[13];
  assign done_rise  = pin_sync_r[12] && !done_seen_r;
  assign res_sync   = pin_sync_r[11:10];
  assign short_sync = pin_sync_r[9];
  assign count_sync = pin_sync_r[8:0];

  // APB: one wait state so read data and ready both leave flops
  logic        access;
  logic        wr_en;
  logic        mapped;
  logic [15:0] wmask;
  assign access = psel_i && penable_i;
  assign wr_en  = access && pready_o && pwrite_i && mapped;
  assign wmask  = {{8{pstrb_i[1]}}, {8{pstrb_i[0]}}};
  always_comb begin
    case (paddr_i)
      `ADDR_EGRESS_LIMITS, `ADDR_PHY_DIAG, `ADDR_PORT_CONFIG,
      `ADDR_IRQ_STATUS, `ADDR_IRQ_MASK, `ADDR_SHAPER_STATUS: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end

  // Egress limits register
  logic [15:0] egress_r;
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i)
      egress_r <= `EGR_RESET;
    else if (wr_en && paddr_i == `ADDR_EGRESS_LIMITS)
      egress_r <= (egress_r & ~wmask) | (pwdata_i[15:0] & wmask);
  end

  // Port configuration: queue mode and test start
  logic multi_queue_r;
  logic start_req;
  assign start_req = wr_en && paddr_i == `ADDR_PORT_CONFIG && pstrb_i[0] && pwdata_i[`CFG_TEST_START_BIT];
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i)
      multi_queue_r <= `CFG_MULTI_QUEUE_RST;
    else if (wr_en && paddr_i == `ADDR_PORT_CONFIG && pstrb_i[0])
      multi_queue_r <= pwdata_i[`CFG_MULTI_QUEUE_BIT];
  end

  // Effective codes after speed clamp and queue mode
  for (genvar q = 0; q < NQ; q++) begin : g_code
    rate_code_t raw;
    rate_code_t eff_r;
    assign raw = egress_r[q*`EGR_FIELD_W +: `EGR_FIELD_W];
    always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i)
        eff_r <= `RATE_UNLIMITED;
      else if (q != 0 && !multi_queue_r)
        eff_r <= `RATE_UNLIMITED;
      else if (speed_10m && raw >= `RATE_FIRST_ABOVE_10M)
        eff_r <= `RATE_UNLIMITED;
      else
        eff_r <= raw;
    end
    assign sh.eff_code[q] = eff_r;
  end

  // Refill tick divider
  logic [15:0] tick_cnt_r;
  logic        tick_r;
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      tick_cnt_r <= 16'h0000;
      tick_r     <= 1'b0;
    end else if (tick_cnt_r == 16'(TICK_CYCLES - 1)) begin
      tick_cnt_r <= 16'h0000;
      tick_r     <= 1'b1;
    end else begin
      tick_cnt_r <= tick_cnt_r + 16'h0001;
      tick_r     <= 1'b0;
    end
  end
  assign sh.tick   = tick_r;
  assign sh.tx_req = tx_req_i;

  egress_shaper #(.NQ(NQ)) u_shaper (
    .sys_clk_i (sys_clk_i),
    .sys_rst_i (sys_rst_i),
    .sh        (sh.shape)
  );
  assign tx_grant_o = sh.tx_grant;

  // Cable test sequencer
  diag_state_t  diag_state_r;
  logic         near_short_r;
  diag_result_t result_r;
  logic [8:0]   fault_count_r;
  logic         test_done_evt;
  logic         test_fault_evt;
  assign test_done_evt  = diag_state_r == DIAG_RUN && done_rise;
  assign test_fault_evt = test_done_evt && (res_sync != 2'b00 || short_sync);
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      diag_state_r <= DIAG_IDLE;
      diag_start_o <= 1'b0;
    end else begin
      diag_start_o <= 1'b0;
      case (diag_state_r)
        DIAG_IDLE: begin
          if (start_req) begin
            diag_state_r <= DIAG_RUN;
            diag_start_o <= 1'b1;
          end
        end
        DIAG_RUN: begin
          if (done_rise)
            diag_state_r <= DIAG_IDLE;
        end
        default: diag_state_r <= DIAG_IDLE;
      endcase
    end
  end

  // Results captured once, at completion, so reads never see a half update
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      near_short_r  <= 1'b0;
      result_r      <= 2'b00;
      fault_count_r <= 9'h000;
    end else if (test_done_evt) begin
      near_short_r  <= short_sync;
      result_r      <= res_sync;
      fault_count_r <= count_sync;
    end
  end

  // PHY controls
  logic diag_wr_lo;
  logic diag_wr_hi;
  assign diag_wr_lo = wr_en && paddr_i == `ADDR_PHY_DIAG && pstrb_i[0];
  assign diag_wr_hi = wr_en && paddr_i == `ADDR_PHY_DIAG && pstrb_i[1];
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i)
      force_link_o <= 1'b0;
    else if (diag_wr_hi && pwdata_i[`DIAG_FORCE_LINK_BIT])
      force_link_o <= 1'b1;
    else if (link_good)
      force_link_o <= 1'b0;
  end

  logic pwr_save_dis_r;
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      pwr_save_dis_r    <= `DIAG_PWR_SAVE_RESET;
      power_save_en_o   <= ~`DIAG_PWR_SAVE_RESET;
      remote_loopback_o <= 1'b0;
    end else begin
      if (diag_wr_hi) begin
        pwr_save_dis_r    <= pwdata_i[`DIAG_PWR_SAVE_BIT];
        power_save_en_o   <= ~pwdata_i[`DIAG_PWR_SAVE_BIT];
        remote_loopback_o <= pwdata_i[`DIAG_LOOPBACK_BIT];
      end
    end
  end

  // Interrupts: set wins over a same-cycle write-one clear
  logic [`IRQ_W-1:0] irq_stat_r;
  logic [`IRQ_W-1:0] irq_mask_r;
  logic [`IRQ_W-1:0] irq_set;
  logic [`IRQ_W-1:0] irq_clr;
  assign irq_set = {test_fault_evt, test_done_evt};
  assign irq_clr = (wr_en && paddr_i == `ADDR_IRQ_STATUS && pstrb_i[0]) ? pwdata_i[`IRQ_W-1:0] : 2'b00;
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      irq_stat_r <= 2'b00;
      irq_mask_r <= 2'b00;
      irq_o      <= 1'b0;
    end else begin
      irq_stat_r <= (irq_stat_r & ~irq_clr) | irq_set;
      if (wr_en && paddr_i == `ADDR_IRQ_MASK && pstrb_i[0])
        irq_mask_r <= pwdata_i[`IRQ_W-1:0];
      irq_o <= |(((irq_stat_r & ~irq_clr) | irq_set) & irq_mask_r);
    end
  end

  // Read mux
  logic [15:0] diag_rd;
  logic [15:0] rd_val;
  assign diag_rd = {near_short_r, result_r, diag_state_r == DIAG_RUN, force_link_o,
                    pwr_save_dis_r, remote_loopback_o, fault_count_r};
  always_comb begin
    case (paddr_i)
      `ADDR_EGRESS_LIMITS: rd_val = egress_r;
      `ADDR_PHY_DIAG:      rd_val = diag_rd;
      `ADDR_PORT_CONFIG:   rd_val = {15'h0000, multi_queue_r};
      `ADDR_IRQ_STATUS:    rd_val = {14'h0000, irq_stat_r};
      `ADDR_IRQ_MASK:      rd_val = {14'h0000, irq_mask_r};
      `ADDR_SHAPER_STATUS: rd_val = {12'h000, sh.throttled};
      default:             rd_val = 16'h0000;
    endcase
  end

  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      pready_o  <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o  <= 32'h0000_0000;
    end else if (access && !pready_o) begin
      pready_o  <= 1'b1;
      pslverr_o <= !mapped;
      prdata_o  <= (!pwrite_i && mapped) ? {16'h0000, rd_val} : 32'h0000_0000;
    end else begin
      pready_o  <= 1'b0;
      pslverr_o <= 1'b0;
    end
  end
endmodule

// ### verif/port_rate_shaper_cable_diag_assertions.sv
`timescale 1ns/1ps
`include "port_shaper_params.svh"
module port_rate_shaper_cable_diag_assertions #(
  parameter int NQ = 4
) (
  input wire logic          sys_clk_i,
  input wire logic          sys_rst_i,
  input wire logic          psel_i,
  input wire logic          penable_i,
  input wire logic          pwrite_i,
  input wire logic [15:0]   paddr_i,
  input wire logic [31:0]   pwdata_i,
  input wire logic [3:0]    pstrb_i,
  input wire logic          pready_o,
  input wire logic          pslverr_o,
  input wire logic [NQ-1:0] tx_req_i,
  input wire logic [NQ-1:0] tx_grant_o,
  input wire logic          link_good_i,
  input wire logic          diag_start_o,
  input wire logic          force_link_o,
  input wire logic          power_save_en_o,
  input wire logic          remote_loopback_o
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (sys_rst_i);
  logic acc;
  logic wr;
  logic mapped;
  logic diag_wr;
  assign acc     = psel_i && penable_i && !pready_o;
  assign wr      = psel_i && penable_i && pready_o && pwrite_i;
  assign mapped  = paddr_i inside {`ADDR_EGRESS_LIMITS, `ADDR_PHY_DIAG, `ADDR_PORT_CONFIG,
                                   `ADDR_IRQ_STATUS, `ADDR_IRQ_MASK, `ADDR_SHAPER_STATUS};
  assign diag_wr = wr && paddr_i == `ADDR_PHY_DIAG && pstrb_i[1];
  a_ready_one_wait: assert property (acc |=> pready_o) else $error("ready late");
  a_ready_pulse: assert property (pready_o |=> !pready_o) else $error("ready too long");
  a_unmapped_err: assert property (acc && !mapped |=> pslverr_o) else $error("no error");
  a_mapped_ok: assert property (acc && mapped |=> !pslverr_o) else $error("false error");
  a_power_save_map: assert property (diag_wr |=> power_save_en_o == !$past(pwdata_i[10]))
    else $error("power save wrong");
  a_loopback_map: assert property (diag_wr |=> remote_loopback_o == $past(pwdata_i[9]))
    else $error("loopback wrong");
  a_force_set: assert property (diag_wr && pwdata_i[11] && !link_good_i && !$past(link_good_i)
    && !$past(link_good_i, 2) |=> force_link_o) else $error("force not set");
  a_force_clear: assert property (force_link_o && link_good_i |-> ##[0:4] !force_link_o)
    else $error("force not cleared");
  a_start_pulse: assert property (diag_start_o |=> !diag_start_o) else $error("start long");
  a_start_cause: assert property ($rose(diag_start_o) |->
    $past(wr && paddr_i == `ADDR_PORT_CONFIG && pwdata_i[1])) else $error("stray start");
  a_grant_req: assert property (|tx_grant_o |-> (tx_grant_o & ~$past(tx_req_i)) == '0)
    else $error("grant without request");
  cover property (diag_start_o);
  cover property (pslverr_o);
  cover property (force_link_o && link_good_i);
  cover property (tx_req_i[0] && !tx_grant_o[0]);
endmodule

// ### verif/port_rate_shaper_cable_diag_tb.sv
`timescale 1ns/1ps
`include "port_shaper_params.svh"
module port_rate_shaper_cable_diag_tb;
  import port_shaper_pkg::*;
  localparam int TICK = 40;
  logic         sys_clk_i = 0;
  logic         sys_rst_i = 1;
  logic         psel_i = 0;
  logic         penable_i = 0;
  logic         pwrite_i = 0;
  logic [15:0]  paddr_i = 16'h0000;
  logic [31:0]  pwdata_i = 32'h0000_0000;
  logic [3:0]   pstrb_i = 4'h3;
  logic [31:0]  prdata_o;
  logic         pready_o;
  logic         pslverr_o;
  logic [3:0]   tx_req_i = 4'h0;
  logic [3:0]   tx_grant_o;
  logic         link_speed_10_i = 0;
  logic         link_good_i = 0;
  logic         diag_done_i = 0;
  diag_result_t diag_result_i = 2'h0;
  logic         diag_near_short_i = 0;
  logic [8:0]   diag_fault_count_i = 9'h000;
  logic         diag_start_o;
  logic         force_link_o;
  logic         power_save_en_o;
  logic         remote_loopback_o;
  logic         irq_o;
  logic [31:0]  rdat;
  logic [31:0]  v;
  logic [31:0]  seed = 32'h5df7_267c;
  int           error_cnt = 0;
  int           checked = 0;
  int           cyc = 0;
  int           n;
  int           e;

  port_rate_shaper_cable_diag #(.TICK_CYCLES(TICK)) dut (.*);

  always #12.5 sys_clk_i = ~sys_clk_i;

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  function automatic int rate_kbps(input int c);
    int t[16] = '{0, 64, 128, 256, 512, 1000, 2000, 4000, 8000, 16000,
                  32000, 48000, 64000, 72000, 80000, 88000};
    return t[c];
  endfunction

  task automatic give_verdict();
    $display("checks %0d errors %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Idle cycle first, so back-to-back calls never assign psel twice at one edge
  task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d);
    @(posedge sys_clk_i);
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge sys_clk_i);
    penable_i <= 1'b1;
    do @(posedge sys_clk_i); while (pready_o !== 1'b1);
    rdat = {prdata_o[31:1], prdata_o[0]};
    v[31] = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask

  // Drain leftover credit first so the window sees only the refill rate
  task automatic measure(input int q, input bit drain);
    int k;
    k = 0;
    tx_req_i[q] <= 1'b1;
    repeat (2) @(posedge sys_clk_i);
    while (drain && k < 3) begin
      @(posedge sys_clk_i);
      k = tx_grant_o[q] ? 0 : k + 1;
    end
    n = 0;
    repeat (10 * TICK) begin
      @(posedge sys_clk_i);
      n += int'(tx_grant_o[q]);
    end
    tx_req_i[q] <= 1'b0;
  endtask

  always @(posedge sys_clk_i) begin
    cyc++;
    if (cyc == 60000) begin
      error_cnt++;
      give_verdict();
    end
  end

  initial begin
    repeat (8) @(posedge sys_clk_i);
    sys_rst_i <= 1'b0;
    apb(0, `ADDR_EGRESS_LIMITS, 0);
    chk(rdat, 32'h0000_0000);
    apb(0, `ADDR_PHY_DIAG, 0);
    chk(rdat, 32'h0000_0400);
    chk({31'h0, power_save_en_o}, 32'h0000_0000);
    apb(0, 16'h1434, 0);
    chk({rdat[30:0], v[31]}, 32'h0000_0001);
    for (int i = 0; i < 4; i++) begin
      e = (i == 0) ? 32'hFFFF_FFFF : rnd();
      apb(1, `ADDR_EGRESS_LIMITS, e);
      apb(0, `ADDR_EGRESS_LIMITS, 0);
      chk(rdat, {16'h0000, e[15:0]});
    end
    e = rnd() | 32'h0000_0800;
    apb(1, `ADDR_PHY_DIAG, e);
    apb(0, `ADDR_PHY_DIAG, 0);
    chk(rdat, {16'h0000, 4'h0, e[11:9], 9'h000});
    chk({29'h0, force_link_o, power_save_en_o, remote_loopback_o}, {29'h0, 1'b1, ~e[10], e[9]});
    link_good_i <= 1'b1;
    repeat (6) @(posedge sys_clk_i);
    apb(0, `ADDR_PHY_DIAG, 0);
    chk({rdat[11], force_link_o}, 32'h0000_0000);
    link_good_i <= 1'b0;
    for (int r = 0; r < 4; r++) begin
      e = rnd();
      diag_result_i <= r[1:0];
      diag_near_short_i <= e[9];
      diag_fault_count_i <= e[8:0];
      apb(1, `ADDR_IRQ_MASK, (r == 0) ? 0 : 3);
      apb(1, `ADDR_PORT_CONFIG, 32'h0000_0003);
      apb(0, `ADDR_PHY_DIAG, 0);
      chk(rdat & 32'h0000_1000, 32'h0000_1000);
      diag_done_i <= 1'b1;
      repeat (5) @(posedge sys_clk_i);
      apb(0, `ADDR_PHY_DIAG, 0);
      chk(rdat & 32'h0000_E1FF, {16'h0000, e[9], r[1:0], 4'h0, e[8:0]});
      chk({31'h0, irq_o}, {31'h0, r != 0});
      apb(0, `ADDR_IRQ_STATUS, 0);
      chk(rdat, {30'h0, (r != 0) || e[9], 1'b1});
      apb(1, `ADDR_IRQ_STATUS, 3);
      apb(0, `ADDR_IRQ_STATUS, 0);
      chk({rdat[30:0], irq_o}, 32'h0000_0000);
      diag_done_i <= 1'b0;
      repeat (4) @(posedge sys_clk_i);
    end
    apb(1, `ADDR_EGRESS_LIMITS, 0);
    measure(2, 0);
    chk({31'h0, n >= 10 * TICK - 2}, 32'h0000_0001);
    for (int c = 1; c < 4; c++) begin
      apb(1, `ADDR_EGRESS_LIMITS, c);
      measure(0, 1);
      e = rate_kbps(c) * 10 / 8;
      chk({31'h0, n >= e - e / 10 && n <= e + e / 10}, 32'h0000_0001);
    end
    link_speed_10_i <= 1'b1;
    apb(1, `ADDR_EGRESS_LIMITS, 32'h0000_A900);
    measure(3, 0);
    chk({31'h0, n >= 10 * TICK - 2}, 32'h0000_0001);
    measure(2, 0);
    chk({31'h0, n >= 10 * TICK - 2}, 32'h0000_0001);
    link_speed_10_i <= 1'b0;
    apb(1, `ADDR_PORT_CONFIG, 0);
    apb(1, `ADDR_EGRESS_LIMITS, 32'h0000_1111);
    measure(1, 0);
    chk({31'h0, n >= 10 * TICK - 2}, 32'h0000_0001);
    measure(0, 1);
    chk({31'h0, n >= 72 && n <= 88}, 32'h0000_0001);
    give_verdict();
  end
endmodule

bind port_rate_shaper_cable_diag port_rate_shaper_cable_diag_assertions #(.NQ(NQ)) chk_i (.*);
